// file: hw/sfc_regs.vh
// Operation
// - read-config instruction returns eight-bit register
// - write-registers needs sixteen cycles, second byte config
// - latency code bits 7:6 set mode/dummy
// - suitable mode bits allow instruction-less repeat
// - plain reads: zero mode/dummy, 50 MHz max
// - code 10b serves fast and multi reads
// - table set chosen by build parameter
// - high performance: only quad io has mode
// - enhanced adds mode to dual io, ddr reads
// - learning pattern only with five+ dummies
// - high performance single-rate dummy table
// - high performance double-rate table
// - enhanced single-rate: dual io 4 mode
// - enhanced double-rate table
// - protect origin bit five, one-time
// - parameter location bit two, one-time
// - bit one selects four-bit io
// - freeze bit zero locks protection bits
// - volatility bit: block protect resets 111
// - one-time bit 1->0 fails, program error
// - freeze cleared only by power/hardware reset
// - quad mode: wp/hold pins inactive internally
`ifndef SFC_REGS_VH
`define SFC_REGS_VH
`define SFC_CMD_READ_CONFIG 8'h35
`define SFC_CMD_WRITE_REGS 8'h01
`define SFC_CMD_WREN 8'h06
`define SFC_CMD_READ 8'h03
`define SFC_CMD_READ4 8'h13
`define SFC_CMD_FAST 8'h0B
`define SFC_CMD_FAST4 8'h0C
`define SFC_CMD_DOUT 8'h3B
`define SFC_CMD_DOUT4 8'h3C
`define SFC_CMD_QOUT 8'h6B
`define SFC_CMD_QOUT4 8'h6C
`define SFC_CMD_DIO 8'hBB
`define SFC_CMD_DIO4 8'hBC
`define SFC_CMD_QIO 8'hEB
`define SFC_CMD_QIO4 8'hEC
`define SFC_CMD_DDR_FAST 8'h0D
`define SFC_CMD_DDR_FAST4 8'h0E
`define SFC_CMD_DDR_DIO 8'hBD
`define SFC_CMD_DDR_DIO4 8'hBE
`define SFC_CMD_DDR_QIO 8'hED
`define SFC_CMD_DDR_QIO4 8'hEE
`define SFC_CFG_RESET 8'h00
`define SFC_BIT_LC_HI 7
`define SFC_BIT_LC_LO 6
`define SFC_BIT_ORIGIN 5
`define SFC_BIT_RSVD 4
`define SFC_BIT_VOLAT 3
`define SFC_BIT_PARAM 2
`define SFC_BIT_QUAD 1
`define SFC_BIT_FREEZE 0
`define SFC_BP_VOLATILE_RESET 3'h7
`define SFC_WRITE_BITS 16
`define SFC_DLP_MIN_DUMMY 4'h5
`define SFC_MODE_CONT 4'hA
`endif

// file: hw/sfc_sync.v
`timescale 1ns/1ps
`default_nettype none
module sfc_sync #(
  parameter WIDTH = 1
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire ce_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  // two-flop synchroniser; stage1 feeds only sync_out
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// file: hw/sfc_latency.v
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.vh"
module sfc_latency #(
  parameter ENHANCED = 0
) (
  input wire [7:0] cmd_in,
  input wire [1:0] latency_code_in,
  output reg [3:0] mode_cycles_out,
  output reg [3:0] dummy_cycles_out,
  output reg has_mode_out,
  output reg is_ddr_out,
  output reg learning_pattern_ok_out
);
  // pick one of four codes ordered 11,00,01,10
  function [3:0] sfc_pick;
    input [1:0] lc;
    input [3:0] v11;
    input [3:0] v00;
    input [3:0] v01;
    input [3:0] v10;
    begin
      case (lc)
        2'b11: sfc_pick = v11;
        2'b00: sfc_pick = v00;
        2'b01: sfc_pick = v01;
        default: sfc_pick = v10;
      endcase
    end
  endfunction

  // fixed tables; variant is a build choice, no register bit
  always @* begin
    mode_cycles_out = 4'h0;
    dummy_cycles_out = 4'h0;
    is_ddr_out = 1'b0;
    case (cmd_in)
      `SFC_CMD_READ, `SFC_CMD_READ4: begin
        dummy_cycles_out = 4'h0;
      end
      `SFC_CMD_FAST, `SFC_CMD_FAST4, `SFC_CMD_DOUT, `SFC_CMD_DOUT4,
      `SFC_CMD_QOUT, `SFC_CMD_QOUT4: begin
        // code 10 also covers fast read up to 133 MHz
        dummy_cycles_out = sfc_pick(latency_code_in, 4'h0, 4'h8, 4'h8, 4'h8);
      end
      `SFC_CMD_DIO, `SFC_CMD_DIO4: begin
        if (ENHANCED != 0) begin
          mode_cycles_out = 4'h4;
          dummy_cycles_out = sfc_pick(latency_code_in, 4'h0, 4'h0, 4'h1, 4'h2);
        end else begin
          dummy_cycles_out = sfc_pick(latency_code_in, 4'h4, 4'h4, 4'h5, 4'h6);
        end
      end
      `SFC_CMD_QIO, `SFC_CMD_QIO4: begin
        mode_cycles_out = 4'h2;
        dummy_cycles_out = sfc_pick(latency_code_in, 4'h1, 4'h4, 4'h4, 4'h5);
      end
      `SFC_CMD_DDR_FAST, `SFC_CMD_DDR_FAST4: begin
        is_ddr_out = 1'b1;
        if (ENHANCED != 0) begin
          mode_cycles_out = 4'h4;
          dummy_cycles_out = sfc_pick(latency_code_in, 4'h1, 4'h2, 4'h4, 4'h5);
        end else begin
          dummy_cycles_out = sfc_pick(latency_code_in, 4'h4, 4'h5, 4'h6, 4'h7);
        end
      end
      `SFC_CMD_DDR_DIO, `SFC_CMD_DDR_DIO4: begin
        is_ddr_out = 1'b1;
        if (ENHANCED != 0) begin
          mode_cycles_out = 4'h2;
          dummy_cycles_out = sfc_pick(latency_code_in, 4'h2, 4'h4, 4'h5, 4'h6);
        end else begin
          dummy_cycles_out = sfc_pick(latency_code_in, 4'h4, 4'h6, 4'h7, 4'h8);
        end
      end
      `SFC_CMD_DDR_QIO, `SFC_CMD_DDR_QIO4: begin
        is_ddr_out = 1'b1;
        mode_cycles_out = 4'h1;
        dummy_cycles_out = sfc_pick(latency_code_in, 4'h3, 4'h6, 4'h7, 4'h8);
      end
      default: begin
        mode_cycles_out = 4'h0;
      end
    endcase
    has_mode_out = (mode_cycles_out != 4'h0);
    learning_pattern_ok_out = is_ddr_out &&
      (dummy_cycles_out >= `SFC_DLP_MIN_DUMMY);
  end
endmodule
`default_nettype wire

// file: hw/sfc_config.v
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.vh"
module sfc_config #(
  parameter ENHANCED = 0
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire ce_in,
  input wire sck_in,
  input wire cs_n_in,
  input wire si_in,
  input wire wp_n_in,
  input wire hold_n_in,
  input wire soft_reset_in,
  output reg so_out,
  output reg so_oe_out,
  output reg [7:0] interface_protection_config_out,
  output reg [2:0] block_protect_field_out,
  output reg program_error_out,
  output reg [3:0] mode_cycles_out,
  output reg [3:0] dummy_cycles_out,
  output reg learning_pattern_ok_out,
  output reg continuous_mode_out,
  output wire quad_enable_out,
  output wire wp_n_eff_out,
  output wire hold_n_eff_out
);
  localparam ST_IDLE = 3'd0;
  localparam ST_CMD = 3'd1;
  localparam ST_WDATA = 3'd2;
  localparam ST_RDATA = 3'd3;
  localparam ST_ADDR = 3'd4;
  localparam ST_MODE = 3'd5;
  localparam ST_SKIP = 3'd6;

  wire [4:0] sync_bus;
  wire sck_s;
  wire cs_n_s;
  wire si_s;
  wire wp_n_s;
  wire hold_n_s;
  reg sck_d;
  reg [2:0] state;
  reg [4:0] bit_cnt;
  reg [7:0] shift_in;
  reg [7:0] shift_out;
  reg [15:0] wdata;
  reg [7:0] cur_cmd;
  reg [7:0] mode_sr;
  reg [3:0] mode_left;
  reg [5:0] addr_left;
  reg write_enable;
  reg cont_armed;
  wire [3:0] lat_mode;
  wire [3:0] lat_dummy;
  wire lat_has_mode;
  wire lat_dlp;
  wire sck_rise;
  wire sck_fall;
  wire [7:0] cmd_byte;
  wire [7:0] cfg;
  wire [7:0] wr_cfg;
  wire frozen;
  wire otp_fail;
  reg [7:0] next_cfg;

  // all pins cross into clk_in before any logic looks at them
  sfc_sync #(.WIDTH(5)) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .async_in({sck_in, cs_n_in, si_in, wp_n_in, hold_n_in}),
    .sync_out(sync_bus)
  );
  assign sck_s = sync_bus[4];
  assign cs_n_s = sync_bus[3];
  assign si_s = sync_bus[2];
  assign wp_n_s = sync_bus[1];
  assign hold_n_s = sync_bus[0];
  assign sck_rise = sck_s && !sck_d;
  assign sck_fall = !sck_s && sck_d;
  assign cmd_byte = {shift_in[6:0], si_s};
  assign cfg = interface_protection_config_out;

  sfc_latency #(.ENHANCED(ENHANCED)) u_lat (
    .cmd_in(cur_cmd),
    .latency_code_in(cfg[`SFC_BIT_LC_HI:`SFC_BIT_LC_LO]),
    .mode_cycles_out(lat_mode),
    .dummy_cycles_out(lat_dummy),
    .has_mode_out(lat_has_mode),
    .is_ddr_out(),
    .learning_pattern_ok_out(lat_dlp)
  );

  // quad mode hides the wp/hold functions as inactive high
  assign quad_enable_out = cfg[`SFC_BIT_QUAD];
  assign wp_n_eff_out = quad_enable_out ? 1'b1 : wp_n_s;
  assign hold_n_eff_out = quad_enable_out ? 1'b1 : hold_n_s;
  assign frozen = cfg[`SFC_BIT_FREEZE];
  assign wr_cfg = {wdata[7:0]};
  // clearing a programmed one-time bit fails
  assign otp_fail = (cfg[`SFC_BIT_ORIGIN] & ~wr_cfg[`SFC_BIT_ORIGIN]) |
                    (cfg[`SFC_BIT_VOLAT] & ~wr_cfg[`SFC_BIT_VOLAT]) |
                    (cfg[`SFC_BIT_PARAM] & ~wr_cfg[`SFC_BIT_PARAM]);

  // merge a written byte into the register under the lock rules
  always @* begin
    next_cfg = cfg;
    next_cfg[`SFC_BIT_LC_HI] = wr_cfg[`SFC_BIT_LC_HI];
    next_cfg[`SFC_BIT_LC_LO] = wr_cfg[`SFC_BIT_LC_LO];
    next_cfg[`SFC_BIT_QUAD] = wr_cfg[`SFC_BIT_QUAD];
    next_cfg[`SFC_BIT_FREEZE] = cfg[`SFC_BIT_FREEZE] | wr_cfg[`SFC_BIT_FREEZE];
    next_cfg[`SFC_BIT_VOLAT] = cfg[`SFC_BIT_VOLAT] | wr_cfg[`SFC_BIT_VOLAT];
    if (!frozen) begin
      // origin and parameter bits locked by freeze
      next_cfg[`SFC_BIT_ORIGIN] = cfg[`SFC_BIT_ORIGIN] | wr_cfg[`SFC_BIT_ORIGIN];
      next_cfg[`SFC_BIT_PARAM] = cfg[`SFC_BIT_PARAM] | wr_cfg[`SFC_BIT_PARAM];
    end
    next_cfg[`SFC_BIT_RSVD] = 1'b0;
  end

  // serial command engine, sampling on sck rising, driving on falling
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sck_d <= 1'b0;
      state <= ST_IDLE;
      bit_cnt <= 5'h00;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      wdata <= 16'h0000;
      cur_cmd <= 8'h00;
      mode_sr <= 8'h00;
      mode_left <= 4'h0;
      addr_left <= 6'h00;
      write_enable <= 1'b0;
      cont_armed <= 1'b0;
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
      interface_protection_config_out <= `SFC_CFG_RESET;
      block_protect_field_out <= 3'h0;
      program_error_out <= 1'b0;
      mode_cycles_out <= 4'h0;
      dummy_cycles_out <= 4'h0;
      learning_pattern_ok_out <= 1'b0;
      continuous_mode_out <= 1'b0;
    end else if (ce_in) begin
      sck_d <= sck_s;
      mode_cycles_out <= lat_mode;
      dummy_cycles_out <= lat_dummy;
      learning_pattern_ok_out <= lat_dlp;
      continuous_mode_out <= cont_armed;
      if (soft_reset_in) begin
        // software reset spares freeze; volatile protect goes to 111
        write_enable <= 1'b0;
        if (cfg[`SFC_BIT_VOLAT]) begin
          block_protect_field_out <= `SFC_BP_VOLATILE_RESET;
        end
      end
      if (cs_n_s) begin
        // frame end: a complete 16-bit write commits only if write enable was set
        if (state == ST_WDATA && bit_cnt == 5'd`SFC_WRITE_BITS && write_enable) begin
          write_enable <= 1'b0;
          interface_protection_config_out <= next_cfg;
          if (otp_fail) begin
            program_error_out <= 1'b1;
          end
          if (!frozen) begin
            block_protect_field_out <= wdata[12:10];
          end
        end
        state <= ST_IDLE;
        so_oe_out <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            bit_cnt <= 5'h00;
            if (cont_armed) begin
              // repeat read with implied instruction
              state <= ST_ADDR;
              addr_left <= 6'd24;
            end else begin
              state <= ST_CMD;
            end
          end
          ST_CMD: begin
            if (sck_rise) begin
              shift_in <= cmd_byte;
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == 5'h07) begin
                cur_cmd <= cmd_byte;
                bit_cnt <= 5'h00;
                if (cmd_byte == `SFC_CMD_READ_CONFIG) begin
                  state <= ST_RDATA;
                  shift_out <= cfg;
                end else if (cmd_byte == `SFC_CMD_WRITE_REGS) begin
                  state <= ST_WDATA;
                end else if (cmd_byte == `SFC_CMD_WREN) begin
                  write_enable <= 1'b1;
                  state <= ST_SKIP;
                end else begin
                  state <= ST_ADDR;
                  addr_left <= 6'd24;
                end
              end
            end
          end
          ST_WDATA: begin
            if (sck_rise && bit_cnt != 5'd`SFC_WRITE_BITS) begin
              wdata <= {wdata[14:0], si_s};
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          ST_RDATA: begin
            if (sck_fall) begin
              // register byte shifted out msb first, repeating
              so_oe_out <= 1'b1;
              so_out <= shift_out[7];
              shift_out <= {shift_out[6:0], shift_out[7]};
            end
          end
          ST_ADDR: begin
            if (sck_rise) begin
              addr_left <= addr_left - 6'h01;
              if (addr_left == 6'h01) begin
                state <= lat_has_mode ? ST_MODE : ST_SKIP;
                mode_left <= 4'h8;
                cont_armed <= 1'b0;
              end
            end
          end
          ST_MODE: begin
            if (sck_rise && mode_left != 4'h0) begin
              mode_sr <= {mode_sr[6:0], si_s};
              mode_left <= mode_left - 4'h1;
              if (mode_left == 4'h1) begin
                cont_armed <= ({mode_sr[2:0], si_s} == `SFC_MODE_CONT);
              end
            end
          end
          ST_SKIP: begin
            so_oe_out <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/sfc_config_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_config_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic cs_n_in,
  input wire logic soft_reset_in,
  input wire logic so_oe_out,
  input wire logic [7:0] interface_protection_config_out,
  input wire logic [2:0] block_protect_field_out,
  input wire logic program_error_out,
  input wire logic [3:0] dummy_cycles_out,
  input wire logic learning_pattern_ok_out,
  input wire logic quad_enable_out,
  input wire logic wp_n_eff_out,
  input wire logic hold_n_eff_out
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_RSVD_ZERO: assert property (!interface_protection_config_out[4])
    else $error("reserved config bit reads one");
  AST_ORIGIN_OTP: assert property (interface_protection_config_out[5] |=>
    interface_protection_config_out[5]) else $error("origin bit cleared");
  AST_PARAM_OTP: assert property (interface_protection_config_out[2] |=>
    interface_protection_config_out[2]) else $error("param bit cleared");
  AST_VOLAT_OTP: assert property (interface_protection_config_out[3] |=>
    interface_protection_config_out[3]) else $error("volatility bit cleared");
  AST_PERR_CAUSE: assert property ($rose(program_error_out) |->
    (|{interface_protection_config_out[5], interface_protection_config_out[3],
    interface_protection_config_out[2]})) else $error("program error without set bit");
  AST_FREEZE_SOFT: assert property (interface_protection_config_out[0] && soft_reset_in
    |=> interface_protection_config_out[0] [*3]) else $error("soft reset cleared freeze");
  AST_FREEZE_LOCK: assert property (interface_protection_config_out[0] |=>
    $stable(interface_protection_config_out[5]) && $stable(interface_protection_config_out[2]))
    else $error("frozen bit changed");
  AST_BP_VOLAT: assert property (interface_protection_config_out[3] && soft_reset_in
    |-> ##[1:3] block_protect_field_out == 3'h7) else $error("block protect not 111");
  AST_QUAD_PINS: assert property (quad_enable_out |-> wp_n_eff_out && hold_n_eff_out
    && interface_protection_config_out[1]) else $error("pins active in quad mode");
  AST_LP_DUMMY: assert property (learning_pattern_ok_out |->
    dummy_cycles_out >= 4'h5) else $error("pattern with few dummies");
  AST_SO_RELEASE: assert property ($rose(cs_n_in) |-> ##[1:8] !so_oe_out)
    else $error("data out held after deselect");
  COV_SOFT: cover property (interface_protection_config_out[0] && soft_reset_in);
  COV_LP: cover property (learning_pattern_ok_out);
  COV_READ: cover property ($rose(so_oe_out));
endmodule
bind sfc_config sfc_config_checker chk_i (.clk_in, .sys_rst_in, .cs_n_in, .soft_reset_in,
  .so_oe_out, .interface_protection_config_out, .block_protect_field_out, .program_error_out,
  .dummy_cycles_out, .learning_pattern_ok_out, .quad_enable_out, .wp_n_eff_out,
  .hold_n_eff_out);
`default_nettype wire

// file: verification/sfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
  input wire logic clk_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in
);
  // idle: clock parked low, deselected
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // mode 0 frame, msb first; 48 ns period stays well under 50 MHz
  task automatic xfer(input logic [39:0] bits, input int n, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    // start on a falling edge so no pin moves with the sampling edge
    @(negedge clk_in);
    cs_n_out = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      sck_out = 1'b0;
      si_out = bits[i];
      #24;
      rd = {rd[6:0], so_in};
      sck_out = 1'b1;
      #24;
    end
    sck_out = 1'b0;
    // released line must not keep the last bit
    si_out = ~si_out;
    #24;
    cs_n_out = 1'b1;
    #60;
  endtask
endmodule
`default_nettype wire

// file: verification/spi_flash_config_and_read_latency_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.vh"
module spi_flash_config_and_read_latency_tb_top;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic soft_reset_in = 1'b0;
  logic wp_n_in = 1'b1;
  logic hold_n_in = 1'b1;
  wire logic sck, cs_n, si, so, so_oe, perr, quad, wp_eff, hold_eff, lp_ok, cont;
  wire logic [7:0] cfg;
  wire logic [2:0] bp;
  wire logic [3:0] mode, dummy;
  logic [7:0] rd;
  int error_cnt = 0;
  int n_compared = 0;
  // read commands with mode count and dummy nibbles for codes 11,10,01,00
  localparam logic [7:0] CMDS [6] = '{`SFC_CMD_READ, `SFC_CMD_FAST, `SFC_CMD_DIO,
    `SFC_CMD_QIO, `SFC_CMD_DDR_FAST, `SFC_CMD_DDR_QIO};
  localparam logic [15:0] DUMS [6] = '{16'h0000, 16'h0888, 16'h4654, 16'h1544, 16'h4765,
    16'h3876};
  localparam logic [3:0] MODES [6] = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h0, 4'h1};
  always #2 clk_in = ~clk_in;
  sfc_config #(.ENHANCED(0)) uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1),
    .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .wp_n_in(wp_n_in), .hold_n_in(hold_n_in),
    .soft_reset_in(soft_reset_in), .so_out(so), .so_oe_out(so_oe),
    .interface_protection_config_out(cfg), .block_protect_field_out(bp),
    .program_error_out(perr), .mode_cycles_out(mode), .dummy_cycles_out(dummy),
    .learning_pattern_ok_out(lp_ok), .continuous_mode_out(cont), .quad_enable_out(quad),
    .wp_n_eff_out(wp_eff), .hold_n_eff_out(hold_eff));
  sfc_host_model host (.clk_in(clk_in), .sck_out(sck), .cs_n_out(cs_n), .si_out(si),
    .so_in(so));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // every register write needs the enable latch first
  task automatic wr(input logic [7:0] bpb, input logic [7:0] c);
    host.xfer({16'h0000, `SFC_CMD_WREN}, 8, rd);
    host.xfer({`SFC_CMD_WRITE_REGS, bpb, c}, 24, rd);
  endtask
  task automatic hw_reset;
    sys_rst_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic t_basic;
    chk("cfg_rst", cfg, `SFC_CFG_RESET);
    chk("perr_rst", {7'h00, perr}, 8'h00);
    host.xfer({`SFC_CMD_WRITE_REGS, 8'h00, 8'hC0}, 24, rd);
    chk("no_wren", cfg, 8'h00);
    host.xfer({16'h0000, `SFC_CMD_WREN}, 8, rd);
    host.xfer({8'h00, `SFC_CMD_WRITE_REGS, 8'hC0}, 16, rd);
    chk("short_wr", cfg, 8'h00);
    wr(8'h00, 8'h80);
    chk("cfg_wr", cfg, 8'h80);
    host.xfer({8'h00, `SFC_CMD_READ_CONFIG, 8'h00}, 16, rd);
    chk("rd_cfg", rd, 8'h80);
    chk("so_release", {7'h00, so_oe}, 8'h00);
  endtask
  // mode nibble Ah arms a read with no instruction byte; next frame disarms
  task automatic t_cont;
    host.xfer({`SFC_CMD_QIO, 24'h000100, 8'h0A}, 40, rd);
    chk("cont_set", {7'h00, cont}, 8'h01);
    host.xfer({8'h00, 24'h000200, 8'h00}, 32, rd);
    chk("cont_clr", {7'h00, cont}, 8'h00);
  endtask
  task automatic t_latency;
    int c;
    int lc;
    logic [3:0] d;
    for (lc = 0; lc < 4; lc++) begin
      wr(8'h00, {lc[1:0], 6'h00});
      for (c = 0; c < 6; c++) begin
        host.xfer({16'h0000, CMDS[c]}, 8, rd);
        d = DUMS[c][4*lc +: 4];
        chk("mode", {4'h0, mode}, {4'h0, MODES[c]});
        chk("dummy", {4'h0, dummy}, {4'h0, d});
        if (c > 3) chk("lp_ok", {7'h00, lp_ok}, {7'h00, d >= 4'h5});
      end
    end
  endtask
  task automatic t_otp;
    wr(8'h00, 8'h3C);
    chk("otp_set", cfg, 8'h2C);
    wr(8'h00, 8'h00);
    chk("otp_hold", cfg, 8'h2C);
    chk("perr", {7'h00, perr}, 8'h01);
    wr(8'h00, 8'h2E);
    @(posedge clk_in);
    wp_n_in <= 1'b0;
    hold_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk("quad_pins", {5'h00, quad, wp_eff, hold_eff}, 8'h07);
    hold_n_in <= 1'b1;
    wr(8'h00, 8'h2C);
    repeat (6) @(posedge clk_in);
    chk("ser_pins", {5'h00, quad, wp_eff, hold_eff}, 8'h01);
    wp_n_in <= 1'b1;
  endtask
  task automatic t_freeze;
    wr(8'h04, 8'h2C);
    wr(8'h04, 8'h2D);
    chk("bp_set", {5'h00, bp}, 8'h01);
    wr(8'h1C, 8'h2D);
    chk("bp_frozen", {5'h00, bp}, 8'h01);
    @(posedge clk_in);
    soft_reset_in <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk("bp_soft", {5'h00, bp}, 8'h07);
    chk("frz_soft", {7'h00, cfg[0]}, 8'h01);
    hw_reset();
    chk("frz_hw", {7'h00, cfg[0]}, 8'h00);
  endtask
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    hw_reset();
    t_basic();
    t_latency();
    t_cont();
    t_otp();
    t_freeze();
    wrap_up();
  end
  // hang guard, several times the expected run
  initial begin
    #300000;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
